// ---- rtl/lqt_pkg.sv ----
package lqt_pkg;
	// Register page and addresses
	localparam logic [4:0] LQT_ADDR_MON = 5'h1D;
	localparam logic [4:0] LQT_ADDR_DATA = 5'h1E;
	localparam logic [2:0] LQT_PAGE_LQ = 3'h2;
	// Data register field positions
	localparam int LQT_RESV_HI = 15;
	localparam int LQT_RESV_LO = 14;
	localparam int LQT_SAMPLE_BIT = 13;
	localparam int LQT_WSTB_BIT = 12;
	localparam int LQT_PSEL_HI = 11;
	localparam int LQT_PSEL_LO = 9;
	localparam int LQT_TSEL_BIT = 8;
	localparam int LQT_DATA_HI = 7;
	// Monitor status register field positions
	localparam int LQT_MON_EN_BIT = 15;
	localparam int LQT_WARN_HI = 9;
	// Sizes
	localparam int LQT_NUM_PARAM = 5;
	localparam int LQT_NUM_THR = 10;
	// Reset values and highest valid select code
	localparam logic [15:0] LQT_DATA_RST = 16'h0000;
	localparam logic [15:0] LQT_MON_RST = 16'h0000;
	localparam logic [7:0] LQT_THR_LO_RST = 8'h00;
	localparam logic [7:0] LQT_THR_HI_RST = 8'hFF;
	localparam logic [2:0] LQT_PSEL_MAX = 3'h4;

	// Parameter codes
	typedef enum logic [2:0] {
		LQT_P_EQ_C1 = 3'b000,
		LQT_P_GAIN = 3'b001,
		LQT_P_BLW = 3'b010,
		LQT_P_FOFS = 3'b011,
		LQT_P_FCTL = 3'b100
	} lqt_param_t;

	// Threshold slot from parameter and bound select
	function automatic logic [3:0] lqt_thr_index(input logic [2:0] psel, input logic tsel);
		return {psel, tsel};
	endfunction : lqt_thr_index

	// Codes above the last parameter address nothing
	function automatic logic lqt_param_valid(input logic [2:0] psel);
		return psel <= LQT_PSEL_MAX;
	endfunction : lqt_param_valid
endpackage : lqt_pkg

// ---- rtl/lqt_thr_if.sv ----
`timescale 1ns/100ps
interface lqt_thr_if import lqt_pkg::*; ();
	logic wr_en;
	logic [3:0] wr_idx;
	logic [7:0] wr_data;
	logic [3:0] rd_idx;
	logic [7:0] rd_data;
	logic [LQT_NUM_THR-1:0][7:0] thr_all;
	modport store (input wr_en, wr_idx, wr_data, rd_idx, output rd_data, thr_all);
	modport ctrl (output wr_en, wr_idx, wr_data, rd_idx, input rd_data, thr_all);
endinterface : lqt_thr_if

// ---- rtl/lqt_thr_store.sv ----
`timescale 1ns/100ps
module lqt_thr_store import lqt_pkg::*; (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Threshold access
	lqt_thr_if.store thr
);
	logic [LQT_NUM_THR-1:0][7:0] thr_q;

	// Ten threshold slots, low bound even, high bound odd
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int k = 0; k < LQT_NUM_THR; k++) begin
				thr_q[k] <= (k % 2 == 1) ? LQT_THR_HI_RST : LQT_THR_LO_RST;
			end
		end else if (thr.wr_en && thr.wr_idx < 4'(LQT_NUM_THR)) begin
			thr_q[thr.wr_idx] <= thr.wr_data;
		end
	end

	// Read port and full view for the monitor
	assign thr.rd_data = (thr.rd_idx < 4'(LQT_NUM_THR)) ? thr_q[thr.rd_idx] : 8'h00;
	assign thr.thr_all = thr_q;
endmodule : lqt_thr_store

// ---- rtl/lqt_top.sv ----
`timescale 1ns/100ps
// Function
// - Bits 15:14 ignore writes and always read zero.
// - Setting sample bit captures selected parameter; data field then returns it.
// - Write strobe copies data field into threshold chosen by both selects.
// - Write strobe bit always reads back zero.
// - Three-bit select picks equaliser, gain, wander, offset or frequency control.
// - Bound select zero means low threshold, one means high threshold.
// - With sampling off, strobed write data becomes the addressed threshold's content.
// - With sampling off, reads return the addressed threshold's stored value.
// - With sampling on, reads return captured value, frozen until next sampling.
// - No threshold update while powered down.
// - Data register decoded at 1Eh only on register page 2.
// - Crossed threshold raises interrupt if permitted; status read clears and re-arms.
module lqt_top import lqt_pkg::*; (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [4:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// Management context
	input wire logic [2:0] page_sel_in,
	input wire logic power_down_in,
	input wire logic irq_enable_in,
	// Adapted signal processing values
	input wire logic link_100_ok_in,
	input wire logic [LQT_NUM_PARAM-1:0][7:0] param_value_in,
	// Interrupt request
	output logic lq_irq_out
);
	lqt_thr_if thr ();

	logic sample_q;
	logic [2:0] psel_q;
	logic tsel_q;
	logic [7:0] sample_val_q;
	logic mon_en_q;
	logic [LQT_WARN_HI:0] warn_q;
	logic [LQT_WARN_HI:0] warn_set_w;
	logic armed_q;
	logic irq_q;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic page_ok_w;
	logic data_wr_w;
	logic data_rd_w;
	logic mon_wr_w;
	logic mon_rd_w;
	logic wr_sample_w;
	logic [2:0] wr_psel_w;
	logic [7:0] wr_param_w;
	logic [7:0] data_field_w;
	logic other_rd_w;

	// Threshold storage
	lqt_thr_store u_store (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.thr(thr.store)
	);

	// Address decode, page qualified
	assign page_ok_w = (page_sel_in == LQT_PAGE_LQ);
	assign data_wr_w = reg_wr_in && page_ok_w && (reg_addr_in == LQT_ADDR_DATA);
	assign data_rd_w = reg_rd_in && page_ok_w && (reg_addr_in == LQT_ADDR_DATA);
	assign mon_wr_w = reg_wr_in && page_ok_w && (reg_addr_in == LQT_ADDR_MON);
	assign mon_rd_w = reg_rd_in && page_ok_w && (reg_addr_in == LQT_ADDR_MON);
	assign other_rd_w = reg_rd_in && !(data_rd_w || mon_rd_w);

	// Fields of the incoming write
	assign wr_sample_w = reg_wdata_in[LQT_SAMPLE_BIT];
	assign wr_psel_w = reg_wdata_in[LQT_PSEL_HI:LQT_PSEL_LO];

	// Selected live parameter for a sampling write
	always_comb begin
		wr_param_w = 8'h00;
		if (lqt_param_valid(wr_psel_w)) begin
			wr_param_w = param_value_in[wr_psel_w];
		end
	end

	// Threshold write request, blocked when powered down or code invalid
	assign thr.wr_en = data_wr_w && reg_wdata_in[LQT_WSTB_BIT] && !wr_sample_w
		&& !power_down_in && lqt_param_valid(wr_psel_w);
	assign thr.wr_idx = lqt_thr_index(wr_psel_w, reg_wdata_in[LQT_TSEL_BIT]);
	assign thr.wr_data = reg_wdata_in[LQT_DATA_HI:0];
	assign thr.rd_idx = lqt_thr_index(psel_q, tsel_q);

	// Control fields of the data register; bits 15:14 and 12 not stored
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sample_q <= LQT_DATA_RST[LQT_SAMPLE_BIT];
			psel_q <= LQT_DATA_RST[LQT_PSEL_HI:LQT_PSEL_LO];
			tsel_q <= LQT_DATA_RST[LQT_TSEL_BIT];
		end else if (data_wr_w) begin
			sample_q <= wr_sample_w;
			psel_q <= wr_psel_w;
			tsel_q <= reg_wdata_in[LQT_TSEL_BIT];
		end
	end

	// Sample capture, held until the next sampling write
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sample_val_q <= LQT_DATA_RST[LQT_DATA_HI:0];
		end else if (data_wr_w && wr_sample_w) begin
			sample_val_q <= wr_param_w;
		end
	end

	// Data field as seen on a read
	always_comb begin
		data_field_w = 8'h00;
		if (sample_q) begin
			data_field_w = sample_val_q;
		end else if (lqt_param_valid(psel_q)) begin
			data_field_w = thr.rd_data;
		end
	end

	// Monitor enable
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mon_en_q <= LQT_MON_RST[LQT_MON_EN_BIT];
		end else if (mon_wr_w) begin
			mon_en_q <= reg_wdata_in[LQT_MON_EN_BIT];
		end
	end

	// Threshold compare, only on a valid 100 Mb link
	always_comb begin
		warn_set_w = '0;
		if (mon_en_q && link_100_ok_in) begin
			for (int k = 0; k < LQT_NUM_PARAM; k++) begin
				warn_set_w[2*k] = param_value_in[k] < thr.thr_all[2*k];
				warn_set_w[2*k+1] = param_value_in[k] > thr.thr_all[2*k+1];
			end
		end
	end

	// Sticky warnings, cleared by status read, new event wins
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			warn_q <= LQT_MON_RST[LQT_WARN_HI:0];
		end else begin
			warn_q <= (mon_rd_w ? '0 : warn_q) | warn_set_w;
		end
	end

	// Interrupt raise once, re-armed by status read
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			armed_q <= 1'b1;
			irq_q <= 1'b0;
		end else if (armed_q && irq_enable_in && |warn_set_w) begin
			armed_q <= 1'b0;
			irq_q <= 1'b1;
		end else if (mon_rd_w) begin
			armed_q <= 1'b1;
			irq_q <= 1'b0;
		end
	end

	// Read mux; unmapped or wrong page reads zero
	always_comb begin
		rdata_d = 16'h0000;
		if (data_rd_w) begin
			rdata_d[LQT_SAMPLE_BIT] = sample_q;
			rdata_d[LQT_PSEL_HI:LQT_PSEL_LO] = psel_q;
			rdata_d[LQT_TSEL_BIT] = tsel_q;
			rdata_d[LQT_DATA_HI:0] = data_field_w;
			rdata_d[LQT_RESV_HI:LQT_RESV_LO] = 2'b00;
			rdata_d[LQT_WSTB_BIT] = 1'b0;
		end else if (mon_rd_w) begin
			rdata_d[LQT_MON_EN_BIT] = mon_en_q;
			rdata_d[LQT_WARN_HI:0] = warn_q;
		end
	end

	// Read data register, valid the cycle after the strobe
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign lq_irq_out = irq_q;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	chk_resv_zero: assert property (data_rd_w |=> reg_rdata_out[15:14] == 2'b00)
		else $error("reserved bits not zero");

	chk_strobe_reads_zero: assert property (data_rd_w |=> !reg_rdata_out[LQT_WSTB_BIT])
		else $error("write strobe bit read as one");

	chk_sample_capture: assert property (data_wr_w && wr_sample_w
		|=> sample_val_q == $past(wr_param_w) && sample_q)
		else $error("sample not captured");

	chk_thr_write_data: assert property (thr.wr_en
		|=> thr.thr_all[$past(thr.wr_idx)] == $past(thr.wr_data))
		else $error("threshold not written");

	chk_pd_no_write: assert property (power_down_in |=> $stable(thr.thr_all))
		else $error("threshold changed while powered down");

	chk_sample_frozen: assert property (!(data_wr_w && wr_sample_w)
		|=> $stable(sample_val_q))
		else $error("sampled value moved");

	chk_read_sample: assert property (data_rd_w && sample_q
		|=> reg_rdata_out[7:0] == $past(sample_val_q))
		else $error("sampled value not returned");

	chk_read_threshold: assert property (data_rd_w && !sample_q && lqt_param_valid(psel_q)
		|=> reg_rdata_out[7:0] == $past(thr.thr_all[thr.rd_idx]))
		else $error("threshold read mismatch");

	chk_bad_code_zero: assert property (data_rd_w && !sample_q && !lqt_param_valid(psel_q)
		|=> reg_rdata_out[7:0] == 8'h00)
		else $error("invalid code read nonzero");

	chk_page_decode: assert property (reg_rd_in && page_sel_in != LQT_PAGE_LQ
		|=> reg_rdata_out == 16'h0000)
		else $error("read answered off page");

	chk_warn_clear: assert property (mon_rd_w && !(|warn_set_w)
		|=> warn_q == '0 ##1 !lq_irq_out || |$past(warn_set_w))
		else $error("warnings not cleared by status read");

	chk_irq_raise: assert property (armed_q && irq_enable_in && |warn_set_w
		|=> lq_irq_out && !armed_q)
		else $error("interrupt not raised");

	// Off page or unmapped reads return zero
	chk_other_read_zero: assert property (other_rd_w
		|=> reg_rdata_out == 16'h0000)
		else $error("unmapped read nonzero");

	// Read data only stands after a read strobe
	chk_idle_read_zero: assert property (!reg_rd_in
		|=> reg_rdata_out == 16'h0000)
		else $error("read data without strobe");

	// Writes on another page change nothing
	chk_off_page_write: assert property (reg_wr_in && !page_ok_w
		|=> $stable(thr.thr_all) && $stable(sample_val_q) && $stable(sample_q))
		else $error("write taken off page");

	// Unused select codes never reach storage
	chk_bad_code_write: assert property (data_wr_w && !lqt_param_valid(wr_psel_w)
		|=> $stable(thr.thr_all))
		else $error("threshold written with unused code");

	// Write request only while powered and code valid
	chk_write_gate: assert property (thr.wr_en
		|-> !power_down_in && lqt_param_valid(wr_psel_w))
		else $error("threshold write not gated");

	// Storage moves only on a write request
	chk_no_stray_write: assert property (!thr.wr_en
		|=> $stable(thr.thr_all))
		else $error("threshold changed without write");

	// A sampling write leaves thresholds alone
	chk_sample_no_write: assert property (data_wr_w && wr_sample_w
		|=> $stable(thr.thr_all))
		else $error("sampling write touched thresholds");

	// Bound select lands in the slot's low bit
	chk_bound_slot: assert property (thr.wr_en
		|-> thr.wr_idx[0] == reg_wdata_in[LQT_TSEL_BIT])
		else $error("bound select misrouted");

	// Parameter select lands in the slot's upper bits
	chk_param_slot: assert property (thr.wr_en
		|-> thr.wr_idx[3:1] == wr_psel_w)
		else $error("parameter select misrouted");

	// Select fields follow every data register write
	chk_ctrl_fields: assert property (data_wr_w
		|=> psel_q == $past(wr_psel_w) && tsel_q == $past(reg_wdata_in[LQT_TSEL_BIT]))
		else $error("select fields not stored");

	// Select fields read back as stored
	chk_read_fields: assert property (data_rd_w
		|=> reg_rdata_out[LQT_PSEL_HI:LQT_TSEL_BIT] == $past({psel_q, tsel_q}))
		else $error("select fields read mismatch");

	// Sample bit reads back as stored
	chk_read_sample_bit: assert property (data_rd_w
		|=> reg_rdata_out[LQT_SAMPLE_BIT] == $past(sample_q))
		else $error("sample bit read mismatch");

	// A write with sampling off returns to threshold view
	chk_sample_clear: assert property (data_wr_w && !wr_sample_w
		|=> !sample_q)
		else $error("sampling view not left");

	// Interrupt holds until a status read
	chk_irq_hold: assert property (lq_irq_out && !mon_rd_w
		|=> lq_irq_out)
		else $error("interrupt dropped early");

	// Status read drops a pending interrupt
	chk_irq_clear: assert property (lq_irq_out && mon_rd_w
		|=> !lq_irq_out)
		else $error("interrupt not cleared by status read");

	// Raised interrupt means disarmed
	chk_arm_exclusive: assert property (1'b1
		|-> !(lq_irq_out && armed_q))
		else $error("armed while interrupt pending");

	// No new interrupt while not permitted
	chk_irq_gated: assert property (!irq_enable_in && !lq_irq_out
		|=> !lq_irq_out)
		else $error("interrupt raised while not permitted");

	// Warnings stay until a status read
	chk_warn_sticky: assert property (!mon_rd_w
		|=> (warn_q & $past(warn_q)) == $past(warn_q))
		else $error("warning lost without read");

	// A crossing always lands in the warnings
	chk_warn_set: assert property (|warn_set_w
		|=> (warn_q & $past(warn_set_w)) == $past(warn_set_w))
		else $error("crossing not recorded");

	// Compare idle unless enabled on a good link
	chk_monitor_gate: assert property (!(mon_en_q && link_100_ok_in)
		|-> warn_set_w == '0)
		else $error("warning while monitor idle");

	// Reserved status bits read zero
	chk_mon_resv_zero: assert property (mon_rd_w
		|=> reg_rdata_out[LQT_MON_EN_BIT-1:LQT_WARN_HI+1] == 5'h00)
		else $error("status reserved bits nonzero");
endmodule : lqt_top

// ---- sim/lqt_top_tb.sv ----
`timescale 1ns/100ps
// Compare, count and report a mismatch
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (got), (exp)); end end

module lqt_top_tb import lqt_pkg::*;;
	logic clk_in = 1'b0;
	logic rst_n_in;
	logic [4:0] addr;
	logic [15:0] wdata;
	logic wr;
	logic rd;
	logic [15:0] rdata;
	logic [2:0] page;
	logic pd;
	logic irq_en;
	logic link_ok;
	logic [LQT_NUM_PARAM-1:0][7:0] pv;
	logic irq;
	int errors;
	int checks_done;

	// Clock, 4 ns period
	always #2 clk_in = ~clk_in;

	lqt_top i_lqt_top (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.reg_addr_in(addr),
		.reg_wdata_in(wdata),
		.reg_wr_in(wr),
		.reg_rd_in(rd),
		.reg_rdata_out(rdata),
		.page_sel_in(page),
		.power_down_in(pd),
		.irq_enable_in(irq_en),
		.link_100_ok_in(link_ok),
		.param_value_in(pv),
		.lq_irq_out(irq)
	);

	// One-cycle write strobe
	task wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask : wr_reg

	// One-cycle read strobe, data checked in the following cycle
	task rd_chk(input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 `CHK(rdata, exp)
	endtask : rd_chk

	// Point at a slot without the strobe, then read it back
	task sel_chk(input logic [2:0] p, input logic t, input logic [7:0] exp);
		wr_reg(LQT_ADDR_DATA, {4'h0, p, t, 8'h00});
		rd_chk(LQT_ADDR_DATA, {4'h0, p, t, exp});
	endtask : sel_chk

	// Verdict and end of run
	task test_done;
		if (errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	// Main sequence
	initial begin
		int n;
		rst_n_in = 1'b0;
		addr = 5'h00;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		page = LQT_PAGE_LQ;
		pd = 1'b0;
		irq_en = 1'b1;
		link_ok = 1'b1;
		pv = {LQT_NUM_PARAM{8'h80}};
		errors = 0;
		checks_done = 0;
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rd_chk(LQT_ADDR_DATA, LQT_DATA_RST);
		// Reset contents of all ten slots
		for (int i = 0; i < 10; i++) begin
			sel_chk(i[3:1], i[0], i[0] ? LQT_THR_HI_RST : LQT_THR_LO_RST);
		end
		// High bound crossing raises and a status read clears
		wr_reg(LQT_ADDR_DATA, 16'h117F);
		wr_reg(LQT_ADDR_MON, 16'h8000);
		for (n = 0; n < 8 && irq !== 1'b1; n++) @(posedge clk_in);
		if (irq !== 1'b1) begin
			errors++;
			test_done();
		end
		pv[0] <= 8'h70;
		rd_chk(LQT_ADDR_MON, 16'h8002);
		`CHK(irq, 1'b0)
		rd_chk(LQT_ADDR_MON, 16'h8000);
		// Crossing while not permitted only warns
		irq_en <= 1'b0;
		pv[0] <= 8'h90;
		rd_chk(LQT_ADDR_MON, 16'h8002);
		`CHK(irq, 1'b0)
		pv[0] <= 8'h70;
		irq_en <= 1'b1;
		wr_reg(LQT_ADDR_MON, 16'h0000);
		// Every slot written with the reserved bits set
		for (int i = 0; i < 10; i++) begin
			wr_reg(LQT_ADDR_DATA, {4'hD, i[3:1], i[0], 8'hA0 + i[7:0]});
			rd_chk(LQT_ADDR_DATA, {4'h0, i[3:1], i[0], 8'hA0 + i[7:0]});
		end
		// Strobe while powered down
		pd <= 1'b1;
		wr_reg(LQT_ADDR_DATA, 16'h1033);
		pd <= 1'b0;
		sel_chk(3'h0, 1'b0, 8'hA0);
		// Other page and unmapped address
		page <= 3'h1;
		wr_reg(LQT_ADDR_DATA, 16'h1011);
		rd_chk(LQT_ADDR_DATA, 16'h0000);
		page <= LQT_PAGE_LQ;
		rd_chk(5'h1F, 16'h0000);
		sel_chk(3'h0, 1'b0, 8'hA0);
		// Unused select codes
		for (int p = 5; p < 8; p++) begin
			wr_reg(LQT_ADDR_DATA, {4'h1, p[2:0], 1'b0, 8'h5A});
			rd_chk(LQT_ADDR_DATA, {4'h0, p[2:0], 1'b0, 8'h00});
		end
		for (int i = 0; i < 10; i++) begin
			sel_chk(i[3:1], i[0], 8'hA0 + i[7:0]);
		end
		// Sample each parameter, live value moves afterwards
		for (int k = 0; k < LQT_NUM_PARAM; k++) begin
			pv[k] <= 8'h31 + k[7:0];
			wr_reg(LQT_ADDR_DATA, {4'h2, k[2:0], 1'b0, 8'h00});
			pv[k] <= 8'hEE;
			rd_chk(LQT_ADDR_DATA, {4'h2, k[2:0], 1'b0, 8'h31 + k[7:0]});
		end
		// Sample and strobe together only sample
		wr_reg(LQT_ADDR_DATA, 16'h3044);
		rd_chk(LQT_ADDR_DATA, 16'h20EE);
		sel_chk(3'h0, 1'b0, 8'hA0);
		test_done();
	end
endmodule : lqt_top_tb
